// ---- vdw_pkg.sv ----
// package: constants, types and carriers for the video dram write-cycle controller
package vdw_pkg;
	// apb register offsets
	localparam logic [7:0] VDW_CTRL_OFS = 8'h00;
	localparam logic [7:0] VDW_STAT_OFS = 8'h04;
	localparam logic [7:0] VDW_ADDR_OFS = 8'h08;
	localparam logic [7:0] VDW_DATA_OFS = 8'h0C;
	localparam logic [7:0] VDW_MASK_OFS = 8'h10;
	// control field positions
	localparam int VDW_CTRL_GO_BIT = 0;
	localparam int VDW_CTRL_CYC_LSB = 1;
	localparam int VDW_CTRL_RMW_BIT = 4;
	localparam int VDW_CTRL_INIT_BIT = 5;
	localparam int VDW_CTRL_SCLK_BIT = 6;
	// status field positions
	localparam int VDW_STAT_BUSY_BIT = 0;
	localparam int VDW_STAT_READY_BIT = 1;
	localparam int VDW_STAT_FLAG_BIT = 2;
	localparam int VDW_STAT_FULL_BIT = 3;
	localparam int VDW_STAT_EMPTY_BIT = 4;
	// reset values
	localparam logic [31:0] VDW_CTRL_RST = 32'h0000_0000;
	localparam logic [15:0] VDW_MASK_RST = 16'hFFFF;
	// timing
	localparam int VDW_CLK_NS = 100;
	localparam int VDW_PWRUP_US = 100;
	localparam int VDW_PWRUP_CYC = (VDW_PWRUP_US * 1000 + VDW_CLK_NS - 1) / VDW_CLK_NS;
	localparam int VDW_INIT_CYCLES = 8;
	// read-back hold: three sync stages, agreement, then capture
	localparam int VDW_RDBK_CYC = 5;
	localparam int VDW_FIFO_DEPTH = 8;
	localparam int VDW_DATA_W = 16;
	// cycle kinds
	typedef enum logic [2:0] {
		VDW_CYC_MASKED_NORMAL = 3'h0,
		VDW_CYC_PLAIN_NORMAL = 3'h1,
		VDW_CYC_MASKED_BLOCK = 3'h2,
		VDW_CYC_PLAIN_BLOCK = 3'h3,
		VDW_CYC_LOAD_MASK = 3'h4,
		VDW_CYC_LOAD_COLOR = 3'h5,
		VDW_CYC_REFRESH = 3'h6
	} vdw_cyc_e;
	// sequencer states, gray from idle through pre on the plain write path
	typedef enum logic [3:0] {
		VDW_ST_IDLE = 4'h0,
		VDW_ST_ROW = 4'h1,
		VDW_ST_COL = 4'h3,
		VDW_ST_DATA = 4'h2,
		VDW_ST_END = 4'h6,
		VDW_ST_PRE = 4'h7,
		VDW_ST_RMW_RD = 4'h5,
		VDW_ST_RMW_WR = 4'h4,
		VDW_ST_PWRUP = 4'hC,
		VDW_ST_SCLK = 4'hD
	} vdw_st_e;
	// levels presented at the strobe edges
	typedef struct packed {
		logic func_row;
		logic func_col;
		logic bytes_row;
	} vdw_levels_s;
	// one queued write order
	typedef struct packed {
		logic [2:0] kind;
		logic rmw;
		logic [15:0] addr;
		logic [15:0] data;
		logic [15:0] mask;
	} vdw_order_s;
	localparam int VDW_ORDER_W = $bits(vdw_order_s);
	// pin levels for each cycle kind
	function automatic vdw_levels_s vdw_decode(input logic [2:0] k);
		vdw_levels_s l;
		l = '{func_row: 1'b0, func_col: 1'b0, bytes_row: 1'b1};
		case (k)
			VDW_CYC_MASKED_NORMAL: l = '{1'b0, 1'b0, 1'b0};
			VDW_CYC_PLAIN_NORMAL: l = '{1'b0, 1'b0, 1'b1};
			VDW_CYC_MASKED_BLOCK: l = '{1'b0, 1'b1, 1'b0};
			VDW_CYC_PLAIN_BLOCK: l = '{1'b0, 1'b1, 1'b1};
			VDW_CYC_LOAD_MASK: l = '{1'b1, 1'b0, 1'b1};
			VDW_CYC_LOAD_COLOR: l = '{1'b1, 1'b1, 1'b1};
			default: l = '{1'b0, 1'b0, 1'b1};
		endcase
		return l;
	endfunction
endpackage

// ---- vdw_fifo.sv ----
// synchronous fifo for queued write orders
`timescale 1ns/1ns
`default_nettype none
module vdw_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 8
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data,
	output logic full,
	output logic empty
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_reg;
	logic [AW-1:0] rd_reg;
	logic [AW:0] cnt_reg;
	logic push;
	logic pop;
	// handshake terms
	assign full = (cnt_reg == (AW+1)'(DEPTH));
	assign empty = (cnt_reg == '0);
	assign in_ready = !full;
	assign out_valid = !empty;
	assign push = in_valid && !full;
	assign pop = out_ready && !empty;
	assign out_data = mem[rd_reg];
	// storage
	always_ff @(posedge clk) begin
		if (push) begin
			mem[wr_reg] <= in_data;
		end
	end
	// pointers and count
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			if (push) begin
				wr_reg <= (wr_reg == AW'(DEPTH-1)) ? '0 : wr_reg + 1'b1;
			end
			if (pop) begin
				rd_reg <= (rd_reg == AW'(DEPTH-1)) ? '0 : rd_reg + 1'b1;
			end
			cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule // vdw_fifo
`default_nettype wire

// ---- vdw_sync.sv ----
// three-stage synchroniser with agreement of the last two stages
`timescale 1ns/1ns
`default_nettype none
module vdw_sync (
	input wire logic clk,
	input wire logic nrst,
	input wire logic d,
	output logic q
);
	logic s1_reg;
	logic s2_reg;
	logic s3_reg;
	// shift chain and agreed level
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			s1_reg <= 1'b0;
			s2_reg <= 1'b0;
			s3_reg <= 1'b0;
			q <= 1'b0;
		end else begin
			s1_reg <= d;
			s2_reg <= s1_reg;
			s3_reg <= s2_reg;
			if (s2_reg == s3_reg) begin
				q <= s3_reg;
			end
		end
	end
endmodule // vdw_sync
`default_nettype wire

// ---- vdw_ctrl.sv ----
// controller that sequences write cycles into a video dram
//
// Local design decisions: the address map and the APB interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module vdw_ctrl
	import vdw_pkg::*;
(
	input wire logic ref_clk,
	input wire logic nrst,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	output logic row_strobe_n,
	output logic col_strobe_n,
	output logic write_cmd_n,
	output logic output_enable_n,
	output logic upper_byte_write_strobe_n,
	output logic lower_byte_write_strobe_n,
	output logic special_function_select,
	output logic spare_function_pin,
	output logic serial_shift_clock,
	output logic serial_port_enable_n,
	output logic [15:0] addr_pins,
	output logic [15:0] io_out,
	output logic io_oe_n,
	input wire logic [15:0] io_in,
	input wire logic serial_half_flag
);
	vdw_st_e st_reg;
	logic [31:0] ctrl_reg;
	logic [15:0] addr_reg;
	logic [15:0] data_reg;
	logic [15:0] mask_reg;
	logic [15:0] rdback_reg;
	logic [16:0] wait_reg;
	logic [3:0] init_reg;
	logic ready_reg;
	logic flag_ok_reg;
	vdw_order_s cur_reg;
	vdw_order_s push_order;
	vdw_order_s head;
	vdw_levels_s lv;
	vdw_levels_s cur_lv;
	logic [VDW_ORDER_W-1:0] head_bits;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic fifo_full;
	logic fifo_empty;
	logic flag_sync;
	logic [15:0] io_in_q;
	logic apb_wr;
	logic apb_acc;

	// apb decode; every access answers in its access cycle
	assign apb_acc = psel && penable;
	assign apb_wr = apb_acc && pwrite;
	assign push_order = '{kind: pwdata[VDW_CTRL_CYC_LSB +: 3], rmw: pwdata[VDW_CTRL_RMW_BIT],
		addr: addr_reg, data: data_reg, mask: mask_reg};
	// a go write is queued only when the fifo has room
	assign fifo_in_valid = apb_wr && paddr == VDW_CTRL_OFS && pwdata[VDW_CTRL_GO_BIT];
	assign head = vdw_order_s'(head_bits);
	assign fifo_pop = (st_reg == VDW_ST_IDLE) && ready_reg && fifo_out_valid;
	assign lv = vdw_decode(head.kind);
	assign cur_lv = vdw_decode(cur_reg.kind);

	vdw_fifo #(.WIDTH(VDW_ORDER_W), .DEPTH(VDW_FIFO_DEPTH)) u_fifo (
		.clk(ref_clk),
		.nrst(nrst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(push_order),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(head_bits),
		.full(fifo_full),
		.empty(fifo_empty)
	);

	vdw_sync u_flag_sync (
		.clk(ref_clk),
		.nrst(nrst),
		.d(serial_half_flag),
		.q(flag_sync)
	);

	// read-back data pins pass the same synchroniser style per bit
	genvar gi;
	generate
		for (gi = 0; gi < VDW_DATA_W; gi++) begin : g_io_sync
			vdw_sync u_io (
				.clk(ref_clk),
				.nrst(nrst),
				.d(io_in[gi]),
				.q(io_in_q[gi])
			);
		end
	endgenerate

	// software registers
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			ctrl_reg <= VDW_CTRL_RST;
			addr_reg <= '0;
			data_reg <= '0;
			mask_reg <= VDW_MASK_RST;
		end else if (apb_wr) begin
			case (paddr)
				VDW_CTRL_OFS: ctrl_reg <= pwdata;
				VDW_ADDR_OFS: addr_reg <= pwdata[15:0];
				VDW_DATA_OFS: data_reg <= pwdata[15:0];
				VDW_MASK_OFS: mask_reg <= pwdata[15:0];
				default: ctrl_reg <= ctrl_reg;
			endcase
		end
	end

	// apb answer, read data and error for unmapped or refused pushes
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			if (psel && !penable) begin
				case (paddr)
					VDW_CTRL_OFS: prdata <= ctrl_reg;
					VDW_STAT_OFS: prdata <= {27'h0, fifo_empty, fifo_full, flag_ok_reg,
						ready_reg, (st_reg != VDW_ST_IDLE)};
					VDW_ADDR_OFS: prdata <= {16'h0, addr_reg};
					VDW_DATA_OFS: prdata <= {16'h0, rdback_reg};
					VDW_MASK_OFS: prdata <= {16'h0, mask_reg};
					default: begin
						prdata <= '0;
						pslverr <= 1'b1;
					end
				endcase
				if (pwrite && paddr == VDW_CTRL_OFS && pwdata[VDW_CTRL_GO_BIT] && !fifo_in_ready)
					pslverr <= 1'b1;
			end
		end
	end

	// sequencer: power-up wait, init refreshes, then queued write cycles
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			st_reg <= VDW_ST_PWRUP;
			wait_reg <= '0;
			init_reg <= '0;
			ready_reg <= 1'b0;
			cur_reg <= '0;
		end else begin
			case (st_reg)
				VDW_ST_PWRUP: begin
					wait_reg <= wait_reg + 1'b1;
					if (wait_reg >= 17'(VDW_PWRUP_CYC - 1)) begin
						wait_reg <= '0;
						cur_reg.kind <= VDW_CYC_REFRESH;
						st_reg <= VDW_ST_COL;
					end
				end
				VDW_ST_IDLE: begin
					if (fifo_pop) begin
						cur_reg <= head;
						st_reg <= VDW_ST_ROW;
					end
				end
				VDW_ST_ROW: st_reg <= VDW_ST_COL;
				VDW_ST_COL: begin
					if (cur_reg.kind == VDW_CYC_REFRESH) begin
						st_reg <= VDW_ST_END;
					end else if (cur_reg.rmw) begin
						st_reg <= VDW_ST_RMW_RD;
					end else begin
						st_reg <= VDW_ST_DATA;
					end
				end
				VDW_ST_RMW_RD: begin
					// hold the device's drive until the synchronised read-back settles
					wait_reg <= wait_reg + 1'b1;
					if (wait_reg == 17'(VDW_RDBK_CYC - 1)) begin
						wait_reg <= '0;
						st_reg <= VDW_ST_RMW_WR;
					end
				end
				VDW_ST_RMW_WR: st_reg <= VDW_ST_DATA;
				VDW_ST_DATA: st_reg <= VDW_ST_END;
				VDW_ST_END: st_reg <= VDW_ST_PRE;
				VDW_ST_PRE: begin
					if (!ready_reg) begin
						init_reg <= init_reg + 1'b1;
						if (init_reg == 4'(VDW_INIT_CYCLES - 1)) begin
							st_reg <= VDW_ST_SCLK;
						end else begin
							st_reg <= VDW_ST_COL;
						end
					end else begin
						st_reg <= VDW_ST_IDLE;
					end
				end
				VDW_ST_SCLK: begin
					ready_reg <= 1'b1;
					st_reg <= VDW_ST_IDLE;
				end
				default: st_reg <= VDW_ST_IDLE;
			endcase
		end
	end

	// dram pins; row function level held from before row edge until col edge, where the col level is set
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			row_strobe_n <= 1'b1;
			col_strobe_n <= 1'b1;
			write_cmd_n <= 1'b1;
			output_enable_n <= 1'b1;
			upper_byte_write_strobe_n <= 1'b1;
			lower_byte_write_strobe_n <= 1'b1;
			special_function_select <= 1'b0;
			addr_pins <= '0;
			io_out <= '0;
			io_oe_n <= 1'b1;
		end else begin
			case (st_reg)
				VDW_ST_IDLE: begin
					if (fifo_pop) begin
						// levels set one cycle before the row edge
						special_function_select <= lv.func_row;
						upper_byte_write_strobe_n <= lv.bytes_row;
						lower_byte_write_strobe_n <= lv.bytes_row;
						addr_pins <= head.addr;
						// mask on io at row edge in new-mask mode, unused otherwise
						io_out <= head.mask;
						io_oe_n <= !(head.kind == VDW_CYC_MASKED_NORMAL
							|| head.kind == VDW_CYC_MASKED_BLOCK);
						write_cmd_n <= head.rmw;
					end
				end
				VDW_ST_ROW: begin
					row_strobe_n <= 1'b0;
				end
				VDW_ST_COL: begin
					if (cur_reg.kind == VDW_CYC_REFRESH) begin
						// column before row refresh
						col_strobe_n <= 1'b0;
						io_oe_n <= 1'b1;
					end else begin
						special_function_select <= cur_lv.func_col;
						upper_byte_write_strobe_n <= 1'b1;
						lower_byte_write_strobe_n <= 1'b1;
						io_out <= cur_reg.data;
						io_oe_n <= cur_reg.rmw;
						output_enable_n <= !cur_reg.rmw;
						col_strobe_n <= 1'b0;
					end
				end
				VDW_ST_RMW_RD: begin
					// device data sampled and its outputs turned off at the same edge
					if (wait_reg == 17'(VDW_RDBK_CYC - 1)) begin
						output_enable_n <= 1'b1;
					end
				end
				VDW_ST_RMW_WR: begin
					io_oe_n <= 1'b0;
					write_cmd_n <= 1'b0;
				end
				VDW_ST_DATA: begin
					// both byte strobes together on every write cycle
					upper_byte_write_strobe_n <= 1'b0;
					lower_byte_write_strobe_n <= 1'b0;
				end
				VDW_ST_END: begin
					row_strobe_n <= 1'b0;
				end
				VDW_ST_PRE: begin
					row_strobe_n <= 1'b1;
					col_strobe_n <= 1'b1;
					write_cmd_n <= 1'b1;
					output_enable_n <= 1'b1;
					upper_byte_write_strobe_n <= 1'b1;
					lower_byte_write_strobe_n <= 1'b1;
					special_function_select <= 1'b0;
					io_oe_n <= 1'b1;
				end
				default: io_oe_n <= 1'b1;
			endcase
		end
	end

	// serial clock pulse at start-up; spare pin held low
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			serial_shift_clock <= 1'b0;
			serial_port_enable_n <= 1'b1;
			spare_function_pin <= 1'b0;
			flag_ok_reg <= 1'b0;
		end else begin
			spare_function_pin <= 1'b0;
			serial_port_enable_n <= 1'b1;
			serial_shift_clock <= (st_reg == VDW_ST_SCLK) || ctrl_reg[VDW_CTRL_SCLK_BIT];
			// flag trusted only once a whole serial clock has been applied
			if (serial_shift_clock) begin
				flag_ok_reg <= 1'b1;
			end
		end
	end

	// read-back capture during rmw read phase
	always_ff @(posedge ref_clk or negedge nrst) begin
		if (!nrst) begin
			rdback_reg <= '0;
		end else if (st_reg == VDW_ST_RMW_RD && wait_reg == 17'(VDW_RDBK_CYC - 1)) begin
			rdback_reg <= io_in_q;
		end
	end

	a_spare_low: assert property (@(posedge ref_clk) disable iff (!nrst)
		$past(nrst) |-> !spare_function_pin) else $error("spare pin driven high");
	a_no_early_use: assert property (@(posedge ref_clk) disable iff (!nrst)
		!ready_reg |-> st_reg != VDW_ST_ROW) else $error("write before init done");
	a_bytes_together: assert property (@(posedge ref_clk) disable iff (!nrst)
		upper_byte_write_strobe_n == lower_byte_write_strobe_n)
		else $error("byte strobes staggered");
	a_float_rmw: assert property (@(posedge ref_clk) disable iff (!nrst)
		!output_enable_n |-> io_oe_n) else $error("bus fight with device");
	a_sel_stable: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(row_strobe_n) && ready_reg |-> $stable(special_function_select))
		else $error("select moved at row edge");
	a_rmw_order: assert property (@(posedge ref_clk) disable iff (!nrst)
		st_reg == VDW_ST_RMW_WR |-> $past(st_reg) == VDW_ST_RMW_RD ##1
		(!write_cmd_n && output_enable_n))
		else $error("rmw order broken");
	a_early_write: assert property (@(posedge ref_clk) disable iff (!nrst)
		$fell(col_strobe_n) && ready_reg && !cur_reg.rmw |-> !write_cmd_n && output_enable_n)
		else $error("not an early write");
	a_flag_after: assert property (@(posedge ref_clk) disable iff (!nrst)
		$rose(flag_ok_reg) |-> $past(serial_shift_clock))
		else $error("flag trusted without clock");
	c_plain_write: cover property (@(posedge ref_clk) disable iff (!nrst)
		st_reg == VDW_ST_DATA && cur_reg.kind == VDW_CYC_PLAIN_NORMAL);
	c_rmw: cover property (@(posedge ref_clk) disable iff (!nrst) st_reg == VDW_ST_RMW_WR);
	c_load_color: cover property (@(posedge ref_clk) disable iff (!nrst)
		st_reg == VDW_ST_DATA && cur_reg.kind == VDW_CYC_LOAD_COLOR);
	c_fifo_full: cover property (@(posedge ref_clk) disable iff (!nrst) fifo_full);
endmodule // vdw_ctrl
`default_nettype wire

// ---- vdw_dram_model.sv ----
// behavioural video dram: write decode, mask and color registers
`timescale 1ns/1ns
`default_nettype none
module vdw_dram_model #(
	parameter bit PERSIST = 1'b0
) (
	input wire logic row_strobe_n,
	input wire logic col_strobe_n,
	input wire logic write_cmd_n,
	input wire logic output_enable_n,
	input wire logic upper_byte_write_strobe_n,
	input wire logic lower_byte_write_strobe_n,
	input wire logic special_function_select,
	input wire logic spare_function_pin,
	input wire logic serial_shift_clock,
	input wire logic [15:0] addr_pins,
	input wire logic [15:0] io,
	output logic [15:0] q,
	output logic q_en,
	output logic serial_half_flag,
	output int viol,
	output int refreshes
);
	logic [15:0] mem [256];
	logic [15:0] wmask_reg, color_reg, row_io, col_io, m;
	logic [7:0] a, c;
	logic func_row, func_col, bytes_row, cbr, early, done, flag_on;
	// power-up contents
	initial begin
		foreach (mem[i]) mem[i] = 16'h0000;
		{wmask_reg, color_reg, a, cbr, early, done, flag_on} = '0;
		viol = 0;
		refreshes = 0;
	end
	// row edge: function, byte levels, new mask, refresh with register reset
	always @(negedge row_strobe_n) begin
		#1;
		cbr = !col_strobe_n;
		if ($time < 100000) viol++;
		if (cbr) refreshes++;
		if (cbr) {wmask_reg, color_reg} = '0;
		func_row = special_function_select;
		bytes_row = upper_byte_write_strobe_n && lower_byte_write_strobe_n;
		row_io = io;
		a = addr_pins[7:0];
	end
	// column edge: second function level, register loads
	always @(negedge col_strobe_n) begin
		#1;
		done = 1'b0;
		if (!row_strobe_n && !cbr) begin
			func_col = special_function_select;
			col_io = io;
			early = !write_cmd_n;
			if (func_row && bytes_row && func_col) color_reg = io;
			if (func_row && bytes_row && !func_col) wmask_reg = io;
		end
	end
	// read drive only in late-write cycles
	assign q_en = !row_strobe_n && !col_strobe_n && !output_enable_n && write_cmd_n && !early;
	assign q = mem[a];
	// store at the later of the column and byte strobe falls
	always @(negedge col_strobe_n or negedge write_cmd_n or negedge upper_byte_write_strobe_n
		or negedge lower_byte_write_strobe_n) begin
		#2;
		if (upper_byte_write_strobe_n !== lower_byte_write_strobe_n) viol++;
		else if (!row_strobe_n && !cbr && !done && !func_row && !col_strobe_n && !write_cmd_n
			&& !upper_byte_write_strobe_n) begin
			done = 1'b1;
			if (refreshes < 8) viol++;
			m = bytes_row ? 16'hFFFF : (PERSIST ? wmask_reg : row_io);
			if (!func_col) mem[a] = (mem[a] & ~m) | (io & m);
			else for (int i = 0; i < 4; i++) begin
				c = {a[7:2], 2'(i)};
				if (col_io[i]) mem[c] = (mem[c] & ~m) | (color_reg & m);
			end
		end
	end
	// spare pin must stay low
	always @(posedge spare_function_pin) viol++;
	// half flag floats until the first serial clock
	always @(posedge serial_shift_clock) flag_on = 1'b1;
	assign serial_half_flag = flag_on ? 1'b0 : 1'bz;
endmodule // vdw_dram_model
`default_nettype wire

// ---- vdw_ctrl_tb.sv ----
// testbench: apb orders into the controller, dram model, shadow prediction
`timescale 1ns/1ns
`default_nettype none
module vdw_ctrl_tb;
	import vdw_pkg::*;
	logic ref_clk, nrst, psel, penable, pwrite, pready, pslverr, rerr, prev_row, prev_sfs;
	logic row_strobe_n, col_strobe_n, write_cmd_n, output_enable_n, special_function_select;
	logic upper_byte_write_strobe_n, lower_byte_write_strobe_n, spare_function_pin, q_en;
	logic serial_shift_clock, serial_port_enable_n, io_oe_n, serial_half_flag;
	logic [7:0] paddr, a;
	logic [31:0] pwdata, prdata, rdat;
	logic [15:0] addr_pins, io_out, io_in, q, d, d0, sh_mask, sh_wm, sh_color;
	logic [15:0] sh [256];
	int viol, refreshes, seed;
	int err_count = 0;
	int total_checks = 0;
	int refused = 0;
	// far side drives io only once the controller lets go
	assign io_in = !io_oe_n ? io_out : (q_en ? q : ~io_out);
	vdw_ctrl dut (.ref_clk, .nrst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .row_strobe_n, .col_strobe_n, .write_cmd_n, .output_enable_n,
		.upper_byte_write_strobe_n, .lower_byte_write_strobe_n, .special_function_select,
		.spare_function_pin, .serial_shift_clock, .serial_port_enable_n, .addr_pins, .io_out,
		.io_oe_n, .io_in, .serial_half_flag);
	vdw_dram_model mdl (.row_strobe_n, .col_strobe_n, .write_cmd_n, .output_enable_n,
		.upper_byte_write_strobe_n, .lower_byte_write_strobe_n, .special_function_select,
		.spare_function_pin, .serial_shift_clock, .addr_pins, .io(io_in), .q, .q_en,
		.serial_half_flag, .viol, .refreshes);
	// reference clock
	initial begin
		ref_clk = 1'b0;
		forever #50 ref_clk = ~ref_clk;
	end
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		total_checks++;
		if (got !== exp) begin
			err_count++;
			$display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic give_verdict();
		$display("checks=%0d mismatches=%0d", total_checks, err_count);
		if (err_count == 0 && total_checks > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask
	// one apb transfer, waiting for pready
	task automatic apb(input logic w, input logic [7:0] ad, input logic [31:0] wd);
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rdat = prdata;
		rerr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic wait_stat(input logic [31:0] msk, input logic [31:0] val);
		int n;
		n = 0;
		do begin
			apb(1'b0, VDW_STAT_OFS, 32'h0);
			n++;
		end while ((rdat & msk) !== val && n < 2000);
		if (n >= 2000) chk(rdat & msk, val);
	endtask
	// expected memory and registers after one order
	function automatic void predict(input logic [2:0] k);
		logic [15:0] m;
		logic [7:0] c;
		m = k[0] ? 16'hFFFF : sh_mask;
		if (k == 3'h4) sh_wm = d;
		else if (k == 3'h5) sh_color = d;
		else if (!k[1]) sh[a] = (sh[a] & ~m) | (d & m);
		else for (int i = 0; i < 4; i++) begin
			c = {a[7:2], 2'(i)};
			if (d[i]) sh[c] = (sh[c] & ~m) | (sh_color & m);
		end
	endfunction
	task automatic order(input logic [2:0] k, input logic rmw);
		apb(1'b1, VDW_ADDR_OFS, {24'h0, a});
		apb(1'b1, VDW_DATA_OFS, {16'h0, d});
		apb(1'b1, VDW_CTRL_OFS, {27'h0, rmw, k, 1'b1});
		repeat (3) @(posedge ref_clk);
		wait_stat(32'h11, 32'h10);
		predict(k);
		for (int i = 0; i < 256; i++) chk({16'h0, mdl.mem[i]}, {16'h0, sh[i]});
		chk({mdl.wmask_reg, mdl.color_reg}, {sh_wm, sh_color});
	endtask
	// pin hygiene at every edge
	always @(posedge ref_clk) begin
		if (!io_oe_n && q_en) chk(32'h1, 32'h0);
		if (prev_row && !row_strobe_n) chk({31'h0, special_function_select}, {31'h0, prev_sfs});
		prev_row <= row_strobe_n;
		prev_sfs <= special_function_select;
	end
	// main sequence
	initial begin
		seed = 15;
		{psel, penable, pwrite, paddr, pwdata, nrst} = '0;
		foreach (sh[i]) sh[i] = 16'h0000;
		{sh_wm, sh_color} = '0;
		repeat (12) @(posedge ref_clk);
		nrst <= 1'b1;
		apb(1'b0, VDW_CTRL_OFS, 32'h0);
		chk(rdat, VDW_CTRL_RST);
		apb(1'b0, VDW_MASK_OFS, 32'h0);
		chk(rdat, {16'h0, VDW_MASK_RST});
		apb(1'b0, 8'h14, 32'h0);
		chk({rdat[30:0], rerr}, 32'h1);
		$display("test registers done");
		wait_stat(32'h2, 32'h2);
		chk({31'h0, refreshes >= VDW_INIT_CYCLES}, 32'h1);
		apb(1'b0, VDW_STAT_OFS, 32'h0);
		chk({31'h0, rdat[VDW_STAT_FLAG_BIT]}, 32'h1);
		$display("test power-up done");
		for (int r = 0; r < 3; r++) begin
			for (int k = 0; k < 6; k++) begin
				a = 8'($random(seed));
				d = 16'($random(seed));
				sh_mask = 16'($random(seed));
				if (r == 0) sh_mask = 16'h0000;
				if (r == 1) d[3:0] = 4'hF;
				apb(1'b1, VDW_MASK_OFS, {16'h0, sh_mask});
				order(3'(k), 1'b0);
			end
			$display("test random pass %0d done", r);
		end
		a = 8'h5A;
		d = 16'hA5C3;
		order(3'h1, 1'b0);
		d0 = d;
		d = 16'h3C5A;
		order(3'h1, 1'b1);
		apb(1'b0, VDW_DATA_OFS, 32'h0);
		chk({16'h0, rdat[15:0]}, {16'h0, d0});
		$display("test read-modify-write done");
		for (int i = 0; i < 24; i++) begin
			apb(1'b1, VDW_CTRL_OFS, 32'h3);
			refused += rerr;
		end
		chk({31'h0, refused > 0}, 32'h1);
		order(3'h1, 1'b0);
		$display("test queue overflow done");
		chk(32'(viol), 32'h0);
		give_verdict();
	end
	// hang guard, about twenty thousand cycles
	initial begin
		#2000000;
		err_count++;
		give_verdict();
	end
endmodule // vdw_ctrl_tb
`default_nettype wire
